// >>> rtl/limcb_top.sv
/*
 * Master control register page for the line interface: parallel port
 * register bank, line standard and driver control, digital rail path,
 * transmit pulse shaping and frame pulse output.
 * Assumes port signals synchronous to i_clk and an external line clock
 * input sampled as an ordinary synchronous input.
 */
`timescale 1ns/1ps
`default_nettype none

module limcb_top (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_ce,
	input  wire limcb_pkg::limcb_req_s i_req,
	output logic      [7:0]            o_rdata,
	output logic                       o_rdata_valid,
	input  wire logic                  i_external_line_clock_in,
	input  wire logic                  i_rx_rail_a,
	input  wire logic                  i_rx_rail_b,
	input  wire logic                  i_tx_data_a,
	input  wire logic                  i_tx_data_b,
	output logic                       o_rx_data_a,
	output logic                       o_rx_data_b,
	output logic                       o_rx_strobe,
	output logic                       o_tx_rail_a,
	output logic                       o_tx_rail_b,
	output logic      [6:0]            o_tx_line_tip,
	output logic      [6:0]            o_tx_line_ring,
	output logic                       o_front_end_enable,
	output logic                       o_shared_frame_pulse_pin,
	output limcb_pkg::limcb_ctrl_s     o_ctrl
);
	import limcb_pkg::*;

	// ********************************************************************
	// Register storage
	// ********************************************************************
	logic [7:0]  config_control;
	logic [7:0]  tx_line_shape;
	logic [7:0]  reserved_a;
	logic [7:0]  jitter_attenuator_control;
	logic [7:0]  reserved_b;
	logic [7:0]  reserved_c;
	logic [7:0]  equalizer_high_threshold;
	logic [7:0]  equalizer_low_threshold;
	logic [7:0]  serial_config;
	logic [7:0]  link_ctrl0_select;
	logic [7:0]  link_ctrl1_select;
	logic [7:0]  link_ctrl2_select;
	limcb_coef_t pulse_coefficient_regs [LIMCB_PHASES];

	// ********************************************************************
	// Port decode
	// ********************************************************************
	wire wr_en   = i_ce && i_req.cs && i_req.wr;
	wire rd_en   = i_ce && i_req.cs && i_req.rd;
	wire wr_cfg  = wr_en && (i_req.addr == LIMCB_OFS_CONFIG);
	wire wr_tx   = wr_en && (i_req.addr == LIMCB_OFS_TXSHAPE);
	wire wr_ra   = wr_en && (i_req.addr == LIMCB_OFS_RSVD_A);
	wire wr_ja   = wr_en && (i_req.addr == LIMCB_OFS_JITTER);
	wire wr_rb   = wr_en && (i_req.addr == LIMCB_OFS_RSVD_B);
	wire wr_rc   = wr_en && (i_req.addr == LIMCB_OFS_RSVD_C);
	wire wr_eh   = wr_en && (i_req.addr == LIMCB_OFS_EQ_HIGH);
	wire wr_el   = wr_en && (i_req.addr == LIMCB_OFS_EQ_LOW);
	wire wr_sc   = wr_en && (i_req.addr == LIMCB_OFS_SERIAL);
	wire wr_l0   = wr_en && (i_req.addr == LIMCB_OFS_LINK0);
	wire wr_l1   = wr_en && (i_req.addr == LIMCB_OFS_LINK1);
	wire wr_l2   = wr_en && (i_req.addr == LIMCB_OFS_LINK2);
	wire is_coef = (i_req.addr >= LIMCB_OFS_COEF1) && (i_req.addr <= LIMCB_OFS_COEF4);
	wire [1:0] coef_idx = i_req.addr[1:0];

	// ********************************************************************
	// Register writes
	// ********************************************************************
	// Reserved bits are masked so a stray write cannot disturb them
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			config_control <= LIMCB_RST_REG;
			tx_line_shape  <= LIMCB_RST_REG;
		end else begin
			if (wr_cfg)
				config_control <= i_req.wdata & LIMCB_CONFIG_MASK;
			if (wr_tx)
				tx_line_shape <= i_req.wdata & LIMCB_TXSHAPE_MASK;
		end
	end

	// Reserved registers store what is written; software keeps them zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reserved_a <= LIMCB_RST_REG;
			reserved_b <= LIMCB_RST_REG;
			reserved_c <= LIMCB_RST_REG;
		end else begin
			if (wr_ra)
				reserved_a <= i_req.wdata;
			if (wr_rb)
				reserved_b <= i_req.wdata;
			if (wr_rc)
				reserved_c <= i_req.wdata;
		end
	end

	// Pass-through read/write registers served elsewhere in the device
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			jitter_attenuator_control <= LIMCB_RST_REG;
			equalizer_high_threshold  <= LIMCB_RST_REG;
			equalizer_low_threshold   <= LIMCB_RST_REG;
			serial_config             <= LIMCB_RST_REG;
			link_ctrl0_select         <= LIMCB_RST_REG;
			link_ctrl1_select         <= LIMCB_RST_REG;
			link_ctrl2_select         <= LIMCB_RST_REG;
		end else begin
			if (wr_ja) jitter_attenuator_control <= i_req.wdata;
			if (wr_eh) equalizer_high_threshold  <= i_req.wdata;
			if (wr_el) equalizer_low_threshold   <= i_req.wdata;
			if (wr_sc) serial_config             <= i_req.wdata;
			if (wr_l0) link_ctrl0_select         <= i_req.wdata;
			if (wr_l1) link_ctrl1_select         <= i_req.wdata;
			if (wr_l2) link_ctrl2_select         <= i_req.wdata;
		end
	end

	// One coefficient register per mark phase
	genvar g;
	generate
		for (g = 0; g < LIMCB_PHASES; g++) begin : g_coef
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n)
					pulse_coefficient_regs[g] <= LIMCB_RST_COEF;
				else if (wr_en && is_coef && (coef_idx == 2'(g)))
					pulse_coefficient_regs[g] <= i_req.wdata[LIMCB_COEF_MSB:0];
			end
		end
	endgenerate

	// ********************************************************************
	// Read back
	// ********************************************************************
	logic [7:0] rd_mux;

	// Unmapped offsets below the page read as zero
	always_comb begin
		rd_mux = 8'h00;
		if (is_coef)
			rd_mux = {1'b0, pulse_coefficient_regs[coef_idx]};
		else begin
			case (i_req.addr)
				LIMCB_OFS_CONFIG:  rd_mux = config_control;
				LIMCB_OFS_TXSHAPE: rd_mux = tx_line_shape;
				LIMCB_OFS_RSVD_A:  rd_mux = reserved_a;
				LIMCB_OFS_JITTER:  rd_mux = jitter_attenuator_control;
				LIMCB_OFS_RSVD_B:  rd_mux = reserved_b;
				LIMCB_OFS_RSVD_C:  rd_mux = reserved_c;
				LIMCB_OFS_EQ_HIGH: rd_mux = equalizer_high_threshold;
				LIMCB_OFS_EQ_LOW:  rd_mux = equalizer_low_threshold;
				LIMCB_OFS_SERIAL:  rd_mux = serial_config;
				LIMCB_OFS_LINK0:   rd_mux = link_ctrl0_select;
				LIMCB_OFS_LINK1:   rd_mux = link_ctrl1_select;
				LIMCB_OFS_LINK2:   rd_mux = link_ctrl2_select;
				default:           rd_mux = 8'h00;
			endcase
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata       <= 8'h00;
			o_rdata_valid <= 1'b0;
		end else if (i_ce) begin
			o_rdata_valid <= rd_en;
			if (rd_en)
				o_rdata <= rd_mux;
		end
	end

	// ********************************************************************
	// Decoded controls
	// ********************************************************************
	limcb_ctrl_s ctrl;

	// Field extraction for the rest of the transceiver
	assign ctrl.line_standard_select = config_control[LIMCB_BIT_STANDARD];
	assign ctrl.line_driver_enable   = config_control[LIMCB_BIT_DRV_EN];
	assign ctrl.front_end_disable    = config_control[LIMCB_BIT_FE_DIS];
	assign ctrl.los_threshold_select = config_control[LIMCB_BIT_LOS_SEL];
	assign ctrl.frame_pulse_select   = config_control[LIMCB_BIT_FP_SEL];
	assign ctrl.test_sequence_select = config_control[LIMCB_BIT_TSEQ_SEL];
	assign ctrl.custom_pulse_level   = tx_line_shape[LIMCB_BIT_CUSTOM];
	assign ctrl.tx_build_out         = tx_line_shape[LIMCB_LBO_MSB:0];

	assign o_ctrl             = ctrl;
	assign o_front_end_enable = !ctrl.front_end_disable;

	// ********************************************************************
	// External line clock edge detect
	// ********************************************************************
	// Clock pin is sampled as data; it must run well below i_clk
	logic ext_clk_d;
	wire  ext_rise = i_external_line_clock_in && !ext_clk_d;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ext_clk_d <= 1'b0;
		else if (i_ce)
			ext_clk_d <= i_external_line_clock_in;
	end

	// ********************************************************************
	// Digital rail path
	// ********************************************************************
	// Rails only move in digital mode, each on a rising line clock edge
	wire rail_step = i_ce && ctrl.front_end_disable && ext_rise;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rx_data_a <= 1'b0;
			o_rx_data_b <= 1'b0;
			o_rx_strobe <= 1'b0;
			o_tx_rail_a <= 1'b0;
			o_tx_rail_b <= 1'b0;
		end else if (i_ce) begin
			o_rx_strobe <= rail_step;
			if (rail_step) begin
				o_rx_data_a <= i_rx_rail_a;
				o_rx_data_b <= i_rx_rail_b;
				o_tx_rail_a <= i_tx_data_a;
				o_tx_rail_b <= i_tx_data_b;
			end
		end
	end

	// ********************************************************************
	// Analog transmit shaping
	// ********************************************************************
	// Phase tick: four phases per line bit in analog mode
	logic [1:0] tick_cnt;
	wire        phase_tick = i_ce && !ctrl.front_end_disable;
	logic [6:0] dac;
	logic       mark_pos;
	logic       mark_neg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt <= 2'h0;
			mark_pos <= 1'b0;
			mark_neg <= 1'b0;
		end else if (phase_tick) begin
			tick_cnt <= tick_cnt + 2'h1;
			if (tick_cnt == 2'h3) begin
				mark_pos <= i_tx_data_a;
				mark_neg <= i_tx_data_b;
			end
		end
	end

	limcb_pulse_shaper u_shaper (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_ce        (i_ce),
		.i_tick      (phase_tick),
		.i_mark      (mark_pos | mark_neg),
		.i_custom    (ctrl.custom_pulse_level),
		.i_build_out (ctrl.tx_build_out),
		.i_coef      ({pulse_coefficient_regs[3], pulse_coefficient_regs[2],
		               pulse_coefficient_regs[1], pulse_coefficient_regs[0]}),
		.o_dac       (dac)
	);

	// Drivers off when disabled or when the analog front end is bypassed
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tx_line_tip  <= 7'h00;
			o_tx_line_ring <= 7'h00;
		end else if (i_ce) begin
			o_tx_line_tip  <= (ctrl.line_driver_enable && !ctrl.front_end_disable
				&& mark_pos) ? dac : 7'h00;
			o_tx_line_ring <= (ctrl.line_driver_enable && !ctrl.front_end_disable
				&& mark_neg) ? dac : 7'h00;
		end
	end

	// ********************************************************************
	// Frame pulse
	// ********************************************************************
	// Bit pace follows the rail clock in digital mode, phase count otherwise
	wire bit_step = ctrl.front_end_disable ? ext_rise : (tick_cnt == 2'h3);

	limcb_frame_pulse #(
		.FRAME_BITS (LIMCB_FRAME_BITS),
		.MFRAMES    (LIMCB_MFRAME_CNT)
	) u_frame (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_bit      (bit_step),
		.i_positive (ctrl.frame_pulse_select),
		.o_pulse    (o_shared_frame_pulse_pin)
	);

endmodule
`default_nettype wire

// >>> rtl/limcb_pkg.sv
/*
 * Package for the line interface master control page: register offsets,
 * field positions, reset values, build-out encodings, state types and the
 * packed structs that carry the decoded controls.
 * Assumes an 8-bit parallel processor port with a 5-bit register address.
 */
// Function
// - Standard select bit 7 clear means T1, set means E1.
// - Bit 5 zero turns off both transmit line outputs; one enables them.
// - Bit 4 clear enables analog front end; set selects digital rail mode.
// - Digital mode samples both receive rails on rising external line clock.
// - Digital mode launches both transmit rails on rising external line clock.
// - Bit 3 clear picks 40 dB loss threshold; set picks 20 dB.
// - Bit 2 set: positive 8 kHz pulse on transmit; clear: negative multiframe pulse.
// - Bit 1 set: milliwatt sequence on test slots; clear: pseudo-random generator.
// - Custom level bit clear uses ROM pulse templates chosen by build-out.
// - Custom level set: each of four mark phases uses its coefficient register.
// - Three-bit build-out field in bits 2..0 selects transmit pulse shape.

package limcb_pkg;

	// ********************************************************************
	// Register offsets on the page
	// ********************************************************************
	localparam logic [4:0] LIMCB_OFS_CONFIG  = 5'h10;
	localparam logic [4:0] LIMCB_OFS_TXSHAPE = 5'h11;
	localparam logic [4:0] LIMCB_OFS_RSVD_A  = 5'h12;
	localparam logic [4:0] LIMCB_OFS_JITTER  = 5'h13;
	localparam logic [4:0] LIMCB_OFS_RSVD_B  = 5'h14;
	localparam logic [4:0] LIMCB_OFS_RSVD_C  = 5'h15;
	localparam logic [4:0] LIMCB_OFS_EQ_HIGH = 5'h16;
	localparam logic [4:0] LIMCB_OFS_EQ_LOW  = 5'h17;
	localparam logic [4:0] LIMCB_OFS_SERIAL  = 5'h18;
	localparam logic [4:0] LIMCB_OFS_LINK0   = 5'h19;
	localparam logic [4:0] LIMCB_OFS_LINK1   = 5'h1a;
	localparam logic [4:0] LIMCB_OFS_LINK2   = 5'h1b;
	localparam logic [4:0] LIMCB_OFS_COEF1   = 5'h1c;
	localparam logic [4:0] LIMCB_OFS_COEF4   = 5'h1f;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int LIMCB_BIT_STANDARD  = 7;
	localparam int LIMCB_BIT_DRV_EN    = 5;
	localparam int LIMCB_BIT_FE_DIS    = 4;
	localparam int LIMCB_BIT_LOS_SEL   = 3;
	localparam int LIMCB_BIT_FP_SEL    = 2;
	localparam int LIMCB_BIT_TSEQ_SEL  = 1;
	localparam int LIMCB_BIT_CUSTOM    = 3;
	localparam int LIMCB_LBO_MSB       = 2;
	localparam int LIMCB_COEF_MSB      = 6;

	// Writable masks; reserved positions are held at zero
	localparam logic [7:0] LIMCB_CONFIG_MASK  = 8'hbe;
	localparam logic [7:0] LIMCB_TXSHAPE_MASK = 8'h0f;
	localparam logic [7:0] LIMCB_COEF_MASK    = 8'h7f;

	// ********************************************************************
	// Reset values
	// ********************************************************************
	localparam logic [7:0] LIMCB_RST_REG  = 8'h00;
	localparam logic [6:0] LIMCB_RST_COEF = 7'h00;

	// ********************************************************************
	// Timing and sizes
	// ********************************************************************
	localparam int LIMCB_PHASES      = 4;
	localparam int LIMCB_FRAME_BITS  = 193;
	localparam int LIMCB_MFRAME_CNT  = 12;

	// ROM template amplitudes per build-out code, one level used on all four phases
	localparam logic [6:0] LIMCB_ROM_LEVEL [8] = '{7'h7f, 7'h74, 7'h6a, 7'h60,
		7'h56, 7'h3c, 7'h2a, 7'h1e};

	typedef logic [6:0] limcb_coef_t;

	// Decoded line controls
	typedef struct packed {
		logic       line_standard_select;
		logic       line_driver_enable;
		logic       front_end_disable;
		logic       los_threshold_select;
		logic       frame_pulse_select;
		logic       test_sequence_select;
		logic       custom_pulse_level;
		logic [2:0] tx_build_out;
	} limcb_ctrl_s;

	// Processor port request
	typedef struct packed {
		logic       cs;
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} limcb_req_s;

	// Pulse phase sequencer states
	typedef enum logic [3:0] {
		LIMCB_PH0 = 4'b0001,
		LIMCB_PH1 = 4'b0010,
		LIMCB_PH2 = 4'b0100,
		LIMCB_PH3 = 4'b1000
	} limcb_phase_e;

endpackage

// >>> rtl/limcb_pulse_shaper.sv
/*
 * Transmit mark shaper: walks four phases per mark and picks the DAC
 * coefficient from ROM templates or custom registers.
 * Assumes a phase tick from the parent and a mark request per bit.
 */
`timescale 1ns/1ps
`default_nettype none

module limcb_pulse_shaper (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_ce,
	input  wire logic                     i_tick,
	input  wire logic                     i_mark,
	input  wire logic                     i_custom,
	input  wire logic [2:0]               i_build_out,
	input  wire logic [4*7-1:0]           i_coef,
	output logic      [6:0]               o_dac
);
	import limcb_pkg::*;

	limcb_phase_e state;
	limcb_phase_e next_state;
	logic [1:0]   phase_idx;
	logic [6:0]   next_dac;

	// Phase index from the one-hot state
	assign phase_idx = {state[3] | state[2], state[3] | state[1]};

	// Custom coefficients win only when the custom bit is set
	assign next_dac = !i_mark   ? 7'h00 :
		i_custom ? i_coef[phase_idx*7 +: 7] :
		LIMCB_ROM_LEVEL[i_build_out];

	// Phase sequencer
	always_comb begin
		case (state)
			LIMCB_PH0: next_state = LIMCB_PH1;
			LIMCB_PH1: next_state = LIMCB_PH2;
			LIMCB_PH2: next_state = LIMCB_PH3;
			LIMCB_PH3: next_state = LIMCB_PH0;
			default:   next_state = LIMCB_PH0;
		endcase
	end

	// Advance one phase per tick
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= LIMCB_PH0;
			o_dac <= 7'h00;
		end else if (i_ce && i_tick) begin
			state <= next_state;
			o_dac <= next_dac;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/limcb_frame_pulse.sv
/*
 * Frame pulse generator for the shared frame pulse pin.
 * Assumes a bit strobe per transmitted line bit.
 */
`timescale 1ns/1ps
`default_nettype none

module limcb_frame_pulse #(
	parameter int FRAME_BITS = 193,
	parameter int MFRAMES    = 12
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ce,
	input  wire logic i_bit,
	input  wire logic i_positive,
	output logic      o_pulse
);
	import limcb_pkg::*;

	logic [7:0] bit_cnt;
	logic [3:0] frm_cnt;
	wire        frame_end = (bit_cnt == 8'(FRAME_BITS - 1));
	wire        mf_end    = frame_end && (frm_cnt == 4'(MFRAMES - 1));

	// Bit and frame counters
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bit_cnt <= 8'h00;
			frm_cnt <= 4'h0;
		end else if (i_ce && i_bit) begin
			bit_cnt <= frame_end ? 8'h00 : bit_cnt + 8'h01;
			if (frame_end)
				frm_cnt <= mf_end ? 4'h0 : frm_cnt + 4'h1;
		end
	end

	// Positive per frame, or active-low at multiframe boundary
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_pulse <= 1'b1;
		else if (i_ce)
			o_pulse <= i_positive ? (i_bit && frame_end) : !(i_bit && mf_end);
	end

endmodule
`default_nettype wire

// >>> dv/limcb_props.sv
/* Port checker for limcb_top: read answer, field decode, driver gating,
   rail capture and pulse width. Assumes one clock; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module limcb_props (
	input wire logic                   i_clk,
	input wire logic                   i_rst_n,
	input wire logic                   i_ce,
	input wire limcb_pkg::limcb_req_s  i_req,
	input wire logic [7:0]             o_rdata,
	input wire logic                   o_rdata_valid,
	input wire logic                   i_external_line_clock_in,
	input wire logic                   i_rx_rail_a,
	input wire logic                   i_rx_rail_b,
	input wire logic                   i_tx_data_a,
	input wire logic                   i_tx_data_b,
	input wire logic                   o_rx_data_a,
	input wire logic                   o_rx_data_b,
	input wire logic                   o_rx_strobe,
	input wire logic                   o_tx_rail_a,
	input wire logic                   o_tx_rail_b,
	input wire logic [6:0]             o_tx_line_tip,
	input wire logic [6:0]             o_tx_line_ring,
	input wire logic                   o_front_end_enable,
	input wire logic                   o_shared_frame_pulse_pin,
	input wire limcb_pkg::limcb_ctrl_s o_ctrl
);
	import limcb_pkg::*;
	// ****************
	// Access decode and steps
	// ****************
	wire logic take_wr = i_ce && i_req.cs && i_req.wr;
	wire logic take_rd = i_ce && i_req.cs && i_req.rd;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_cfg_wr; take_wr && i_req.addr == LIMCB_OFS_CONFIG; endsequence
	sequence s_ext_rise; i_ce && o_ctrl.front_end_disable && $rose(i_external_line_clock_in);
	endsequence
	// Write then read of one full-width register, back to back
	sequence s_wr_rd; take_wr && i_req.addr == LIMCB_OFS_JITTER ##1
		take_rd && i_req.addr == LIMCB_OFS_JITTER; endsequence
	// ****************
	// Assertions
	// ****************
	chk_read_answer: assert property (take_rd |=> o_rdata_valid)
		else $error("read not answered one cycle later");
	chk_read_back: assert property (s_wr_rd |=> o_rdata == $past(i_req.wdata, 2))
		else $error("read back differs from write");
	chk_cfg_fields: assert property (s_cfg_wr |=>
		{o_ctrl[9:8], o_front_end_enable, o_ctrl[6:4]} ==
		$past({i_req.wdata[7], i_req.wdata[5], !i_req.wdata[4], i_req.wdata[3:1]}))
		else $error("config fields do not follow write");
	chk_tx_shape: assert property (take_wr && i_req.addr == LIMCB_OFS_TXSHAPE |=>
		o_ctrl[3:0] == $past(i_req.wdata[3:0])) else $error("shape fields wrong");
	chk_drv_off: assert property ((i_ce && !o_ctrl.line_driver_enable) [*2] |->
		(o_tx_line_tip | o_tx_line_ring) == 7'h00) else $error("drivers active while off");
	chk_rail_capture: assert property (s_ext_rise |=> o_rx_strobe &&
		{o_rx_data_a, o_rx_data_b, o_tx_rail_a, o_tx_rail_b} ==
		$past({i_rx_rail_a, i_rx_rail_b, i_tx_data_a, i_tx_data_b}))
		else $error("rails not moved on line clock rise");
	chk_no_strobe: assert property ((!o_ctrl.front_end_disable) [*2] |-> !o_rx_strobe)
		else $error("capture while front end enabled");
	chk_fp_width: assert property (
		i_ce && !o_ctrl.frame_pulse_select && $fell(o_shared_frame_pulse_pin) |=>
		o_shared_frame_pulse_pin) else $error("frame pulse wider than one cycle");
	chk_coef_msb: assert property (take_rd && i_req.addr >= LIMCB_OFS_COEF1 |=> !o_rdata[7])
		else $error("coefficient top bit set");
endmodule
bind limcb_top limcb_props i_limcb_props (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req), .o_rdata(o_rdata),
	.o_rdata_valid(o_rdata_valid), .i_external_line_clock_in(i_external_line_clock_in),
	.i_rx_rail_a(i_rx_rail_a), .i_rx_rail_b(i_rx_rail_b), .i_tx_data_a(i_tx_data_a),
	.i_tx_data_b(i_tx_data_b), .o_rx_data_a(o_rx_data_a), .o_rx_data_b(o_rx_data_b),
	.o_rx_strobe(o_rx_strobe), .o_tx_rail_a(o_tx_rail_a), .o_tx_rail_b(o_tx_rail_b),
	.o_tx_line_tip(o_tx_line_tip), .o_tx_line_ring(o_tx_line_ring),
	.o_front_end_enable(o_front_end_enable), .o_ctrl(o_ctrl),
	.o_shared_frame_pulse_pin(o_shared_frame_pulse_pin));
`default_nettype wire

// >>> dv/limcb_host_model.sv
/* Host processor model on the parallel port: write, read and release.
   Assumes each task is entered just after a falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module limcb_host_model (
	input  wire logic                  i_clk,
	input  wire logic [7:0]            i_rdata,
	input  wire logic                  i_rdata_valid,
	output var limcb_pkg::limcb_req_s  o_req
);
	import limcb_pkg::*;
	// ****************
	// Port cycles
	// ****************
	initial o_req = '0;
	// Held over one rising edge; reserved places get zeros, except coefficient bit 7
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == LIMCB_OFS_CONFIG) v = d & LIMCB_CONFIG_MASK;
		if (a == LIMCB_OFS_TXSHAPE) v = d & LIMCB_TXSHAPE_MASK;
		if (a inside {LIMCB_OFS_RSVD_A, LIMCB_OFS_RSVD_B, LIMCB_OFS_RSVD_C}) v = 8'h00;
		o_req = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge i_clk);
	endtask
	// Answer is taken in the cycle after the taking edge
	task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
		o_req = '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge i_clk);
		d = i_rdata;
		ok = i_rdata_valid;
	endtask
	// Released bus keeps changing so stale values never look valid
	task automatic idle;
		o_req = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~o_req.addr, wdata: ~o_req.wdata};
		@(negedge i_clk);
	endtask
endmodule
`default_nettype wire

// >>> dv/limcb_tb_top.sv
/* Bench for limcb_top: host cycles, line clock and rail stimulus.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module limcb_tb_top;
	import limcb_pkg::*;
	logic        i_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, ext = 1'b0, rxs = 1'b0;
	logic        txs = 1'b0, fp_d = 1'b1, vld, rx_a, rx_b, stb, fe, fp, ok;
	logic [7:0]  rdata, v;
	logic [6:0]  tip, ring;
	limcb_req_s  req;
	limcb_ctrl_s ctrl;
	int          mismatches = 0, samples_checked = 0, cnt = 0, n_stb = 0, fp_t = 0, n0;
	always #5 i_clk = ~i_clk;
	limcb_top i_limcb_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(req),
		.o_rdata(rdata), .o_rdata_valid(vld), .i_external_line_clock_in(ext),
		.i_rx_rail_a(rxs), .i_rx_rail_b(~rxs), .i_tx_data_a(txs), .i_tx_data_b(~txs),
		.o_rx_data_a(rx_a), .o_rx_data_b(rx_b), .o_rx_strobe(stb), .o_tx_rail_a(),
		.o_tx_rail_b(), .o_tx_line_tip(tip), .o_tx_line_ring(ring),
		.o_front_end_enable(fe), .o_shared_frame_pulse_pin(fp), .o_ctrl(ctrl));
	limcb_host_model i_limcb_host_model (.i_clk(i_clk), .i_rdata(rdata),
		.i_rdata_valid(vld), .o_req(req));
	// ****************
	// Tasks
	// ****************
	task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		i_limcb_host_model.wr(a, d);
	endtask
	task automatic idle;
		i_limcb_host_model.idle;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		i_limcb_host_model.rd(a, v, ok);
		chk("read valid", 10'(ok), 10'h1);
		chk("read data", 10'(v), 10'(e));
	endtask
	function automatic logic [7:0] expv(input logic [4:0] a, input logic [7:0] d);
		case (a)
			5'h10: expv = d & 8'hbe;
			5'h11: expv = d & 8'h0f;
			5'h12, 5'h14, 5'h15: expv = 8'h00;
			5'h1c, 5'h1d, 5'h1e, 5'h1f: expv = d & 8'h7f;
			default: expv = d;
		endcase
	endfunction
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************
	// Stimulus and monitors
	// ****************
	// Line clock of eight cycles; receive rails move only while it is low
	always @(negedge i_clk) begin
		cnt <= cnt + 1;
		ext <= cnt[2];
		if (cnt[2:0] == 3'h0) rxs <= cnt[3] ^ cnt[5];
		txs <= cnt[1];
		if (fp !== fp_d) fp_t++;
		fp_d = fp;
		if (stb === 1'b1) begin
			n_stb++;
			chk("rx rails", 10'({rx_a, rx_b}), 10'({rxs, ~rxs}));
		end
	end
	// Hang guard
	initial begin
		repeat (40000) @(posedge i_clk);
		mismatches++;
		final_report;
	end
	// Main sequence
	initial begin
		repeat (20) @(negedge i_clk);
		i_rst_n = 1'b1;
		for (int a = 16; a < 32; a++) begin
			rdc(5'(a), 8'h00);
			wr(5'(a), 8'hc3 ^ 8'(a));
			rdc(5'(a), expv(5'(a), 8'hc3 ^ 8'(a)));
		end
		wr(5'h05, 8'hff);
		rdc(5'h05, 8'h00);
		$display("test read back done");
		for (int b = 1; b < 8; b++) begin
			if (b == 6) continue;
			wr(LIMCB_OFS_CONFIG, 8'h01 << b);
			chk("config", 10'({ctrl[9:4], fe}), 10'({b == 7 ? 6'h20 : 6'(1 << (b - 1)), b != 4}));
		end
		for (int c = 0; c < 16; c++) begin
			wr(LIMCB_OFS_TXSHAPE, 8'(c));
			chk("shape", 10'(ctrl[3:0]), 10'(c));
		end
		$display("test fields done");
		// Marks flow while drivers are off, then custom coefficients
		for (int i = 0; i < 20; i++) begin
			idle;
			chk("line off", 10'(tip | ring), 10'h0);
		end
		for (int a = 28; a < 32; a++) wr(5'(a), 8'h55);
		wr(LIMCB_OFS_TXSHAPE, 8'h08);
		wr(LIMCB_OFS_CONFIG, 8'h20);
		ok = 1'b0;
		for (int i = 0; i < 64 && !ok; i++) begin
			idle;
			ok = (tip === 7'h55 || ring === 7'h55);
		end
		chk("custom level", 10'(ok), 10'h1);
		if (!ok) final_report;
		wr(LIMCB_OFS_TXSHAPE, 8'h05);
		repeat (8) idle;
		chk("rom level", 10'(tip | ring), 10'(LIMCB_ROM_LEVEL[5]));
		$display("test line drive done");
		wr(LIMCB_OFS_CONFIG, 8'h10);
		n0 = n_stb;
		repeat (40) idle;
		chk("captures", 10'(n_stb > n0), 10'h1);
		$display("test rails done");
		for (int m = 0; m < 2; m++) begin
			wr(LIMCB_OFS_CONFIG, m ? 8'h04 : 8'h00);
			repeat (3) idle;
			n0 = fp_t;
			repeat (m ? 900 : 9500) idle;
			chk("frame pulse", 10'(fp_t > n0), 10'h1);
		end
		$display("test frame pulse done");
		// Frozen write, then a second reset in mid-run
		i_ce = 1'b0;
		wr(LIMCB_OFS_EQ_HIGH, 8'h3c);
		i_ce = 1'b1;
		rdc(LIMCB_OFS_EQ_HIGH, 8'hd5);
		i_rst_n = 1'b0;
		idle;
		i_rst_n = 1'b1;
		rdc(LIMCB_OFS_EQ_HIGH, 8'h00);
		$display("test enable and reset done");
		final_report;
	end
endmodule
`default_nettype wire
